// ===== rtl/cts_pkg.sv
// Constants and types shared by the current transformer supervision block
package cts_pkg;
  // Clock and program cycle; the alarm delay LSB is one program cycle (5 ms)
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PROG_CYCLE_US = 5000;
  localparam int unsigned CYCLE_CLKS    = (PROG_CYCLE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 17;

  // Hysteresis and ratio scaling
  localparam int unsigned HYST_LO_PCT = 97;
  localparam int unsigned HYST_HI_PCT = 103;
  localparam int unsigned PCT_FULL    = 100;
  localparam int unsigned RATIO_FULL  = 10000;

  localparam int unsigned STAGES    = 2;
  localparam int unsigned REC_DEPTH = 12;

  // Per-stage byte offsets; stage two sits one span higher
  localparam logic [7:0] STAGE_SPAN = 8'h40;
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_LIMITS = 6'h04;
  localparam logic [5:0] OFS_RATIOS = 6'h08;
  localparam logic [5:0] OFS_ISUM   = 6'h0C;
  localparam logic [5:0] OFS_DELAY  = 6'h10;
  localparam logic [5:0] OFS_STATUS = 6'h14;
  localparam logic [5:0] OFS_COUNT  = 6'h18;
  localparam logic [5:0] OFS_RECSEL = 6'h1C;
  localparam logic [5:0] OFS_REC0   = 6'h20;
  localparam logic [5:0] OFS_REC1   = 6'h24;
  localparam logic [5:0] OFS_REC2   = 6'h28;
  localparam logic [5:0] OFS_REC3   = 6'h2C;
  localparam logic [5:0] OFS_REC4   = 6'h30;
  localparam logic [5:0] OFS_REC5   = 6'h34;
  // Shared read-only values
  localparam logic [7:0] OFS_UNBAL_ANG = 8'h80;
  localparam logic [7:0] OFS_DIFF_MAG  = 8'h84;
  localparam logic [7:0] OFS_DIFF_ANG  = 8'h88;

  // Event bit positions
  localparam int unsigned EV_ALARM_ON  = 0;
  localparam int unsigned EV_ALARM_OFF = 1;
  localparam int unsigned EV_BLOCK_ON  = 2;
  localparam int unsigned EV_BLOCK_OFF = 3;

  typedef enum logic [2:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF} mode_t;
  typedef enum logic [1:0] {RES_NONE, RES_ONE, RES_TWO} res_sel_t;

  typedef struct packed {
    logic [22:0] pad;
    logic [3:0]  ev_mask;
    res_sel_t    res_sel;
    mode_t       mode;
  } ctrl_t;

  // Reset values of the settings
  localparam ctrl_t       CTRL_RST  = '{pad: '0, ev_mask: 4'hF, res_sel: RES_NONE, mode: MODE_ON};
  localparam logic [15:0] HIGH_RST  = 16'h0078;
  localparam logic [15:0] LOW_RST   = 16'h000A;
  localparam logic [13:0] MINMAX_RST = 14'h03E8;
  localparam logic [13:0] UNBAL_RST = 14'h1324;
  localparam logic [15:0] ISUM_RST  = 16'h000A;
  localparam logic [18:0] DELAY_RST = 19'h00064;

  typedef struct packed {
    logic [15:0] l1;
    logic [15:0] l2;
    logic [15:0] l3;
    logic [15:0] res1;
    logic [15:0] res2;
    logic [15:0] pos;
    logic [15:0] neg;
  } cur_t;

  typedef struct packed {
    cur_t        cur;
    logic [15:0] diff1;
    logic [15:0] diff2;
  } meas_t;

  typedef struct packed {
    logic [15:0] unbal_ang;
    logic [15:0] diff_mag;
    logic [15:0] diff_ang;
  } info_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0]  event_id;
    logic [4:0]  fault;
    logic [2:0]  group;
    logic [18:0] remain;
    cur_t        cur;
  } rec_t;

  typedef struct packed {
    ctrl_t                  ctrl;
    logic [15:0]            lim_low;
    logic [15:0]            lim_high;
    logic [13:0]            rat_minmax;
    logic [13:0]            rat_unbal;
    logic [15:0]            isum;
    logic [18:0]            delay;
    logic                   blk;
    logic                   start;
    logic                   blocked;
    logic                   alarm;
    logic                   over_high;
    logic                   under_low;
    logic                   diff_low;
    logic [18:0]            timer;
    logic [3:0]             events;
    logic [31:0]            count;
    logic [3:0]             rec_sel;
    logic [3:0]             rec_wp;
    logic [3:0]             rec_cnt;
    rec_t [REC_DEPTH-1:0]   recs;
  } stage_t;

  typedef struct packed {
    logic              hready;
    logic              hresp;
    logic              rd_pend;
    logic              wr_pend;
    logic [7:0]        ofs;
    logic [31:0]       hrdata;
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
  } top_t;
endpackage

// ===== rtl/current_transformer_supervision.sv
// Current transformer supervision: two stages behind an AHB-Lite register slave
//
// The address map and the AHB-Lite register port are this design's own decisions.

module cts_stage (
  input  wire logic           mclk_in,    // System clock
  input  wire logic           rst_n_in,   // Synchronous reset, active low
  input  wire logic           tick_in,    // Program cycle pulse
  input  wire logic           block_in,   // Blocking input
  input  wire logic [31:0]    time_in,    // Millisecond time stamp
  input  wire logic [2:0]     group_in,   // Active setting group
  input  cts_pkg::meas_t      meas_in,    // Measured magnitudes
  input  wire logic           reg_wr_in,  // Register write strobe
  input  wire logic [5:0]     reg_ofs_in, // Register byte offset
  input  wire logic [31:0]    wdata_in,   // Write data
  output logic [31:0]         rdata_out,  // Read data, combinational
  output logic                alarm_out,  // Alarm level
  output logic                start_out,  // Start level
  output logic                blocked_out, // Blocked level
  output logic [3:0]          event_out   // Event pulses
);
  cts_pkg::stage_t s;
  cts_pkg::stage_t n;

  logic [15:0] imax;
  logic [15:0] imin;
  logic [15:0] dsel;
  logic [31:0] max_x100;
  logic [31:0] high_x97;
  logic [31:0] low_x103;
  logic [31:0] diff_x100;
  logic [31:0] isum_x103;
  logic [31:0] min_full;
  logic [31:0] max_ratio;
  logic [31:0] neg_full;
  logic [31:0] pos_ratio;
  logic        ratio_ok;
  logic        unbal_ok;
  logic        pickup;
  logic        blk_now;
  logic        off_mode;
  logic        ev_alarm_on;
  logic        ev_block_on;
  logic [4:0]  fault;
  logic [18:0] remain;
  logic [4:0]  rd_slot;
  cts_pkg::rec_t rd_rec;
  logic [2:0]  behav;

  always_comb begin
    imax = meas_in.cur.l1;
    imin = meas_in.cur.l1;
    if (meas_in.cur.l2 > imax) imax = meas_in.cur.l2;
    if (meas_in.cur.l3 > imax) imax = meas_in.cur.l3;
    if (meas_in.cur.l2 < imin) imin = meas_in.cur.l2;
    if (meas_in.cur.l3 < imin) imin = meas_in.cur.l3;
  end

  assign dsel      = (s.ctrl.res_sel == cts_pkg::RES_TWO) ? meas_in.diff2 : meas_in.diff1;
  assign max_x100  = 32'(imax) * 32'(cts_pkg::PCT_FULL);
  assign high_x97  = 32'(s.lim_high) * 32'(cts_pkg::HYST_LO_PCT);
  assign low_x103  = 32'(s.lim_low) * 32'(cts_pkg::HYST_HI_PCT);
  assign diff_x100 = 32'(dsel) * 32'(cts_pkg::PCT_FULL);
  assign isum_x103 = 32'(s.isum) * 32'(cts_pkg::HYST_HI_PCT);
  assign min_full  = 32'(imin) * 32'(cts_pkg::RATIO_FULL);
  assign max_ratio = 32'(imax) * 32'(s.rat_minmax);
  assign neg_full  = 32'(meas_in.cur.neg) * 32'(cts_pkg::RATIO_FULL);
  assign pos_ratio = 32'(meas_in.cur.pos) * 32'(s.rat_unbal);

  assign ratio_ok = (min_full <= max_ratio);
  assign unbal_ok = (neg_full > pos_ratio);

  assign off_mode = (s.ctrl.mode == cts_pkg::MODE_OFF) || (s.ctrl.mode > cts_pkg::MODE_OFF);
  assign behav    = off_mode ? 3'(cts_pkg::MODE_OFF) : 3'(s.ctrl.mode);
  // block level taken at cycle start
  assign blk_now  = block_in || (s.ctrl.mode == cts_pkg::MODE_BLOCKED)
                    || (s.ctrl.mode == cts_pkg::MODE_TEST_BLOCKED);
  assign fault    = {s.over_high, s.under_low, ratio_ok, unbal_ok, ~s.diff_low};
  assign remain   = (s.delay > s.timer) ? (s.delay - s.timer) : 19'h00000;

  always_comb begin
    n = s;
    n.events = 4'h0;
    if (reg_wr_in) begin
      case (reg_ofs_in)
        cts_pkg::OFS_CTRL: n.ctrl = cts_pkg::ctrl_t'({23'h000000, wdata_in[8:0]});
        cts_pkg::OFS_LIMITS: begin
          n.lim_low  = wdata_in[15:0];
          n.lim_high = wdata_in[31:16];
        end
        cts_pkg::OFS_RATIOS: begin
          n.rat_minmax = wdata_in[13:0];
          n.rat_unbal  = wdata_in[29:16];
        end
        cts_pkg::OFS_ISUM:   n.isum    = wdata_in[15:0];
        cts_pkg::OFS_DELAY:  n.delay   = wdata_in[18:0];
        cts_pkg::OFS_COUNT:  n.count   = 32'h00000000;
        cts_pkg::OFS_RECSEL: n.rec_sel = wdata_in[3:0];
        default: n.rec_sel = s.rec_sel;
      endcase
    end
    if (tick_in) begin
      n.blk = blk_now;
      // high limit drops out at 97 percent
      if (imax > s.lim_high) n.over_high = 1'b1;
      else if (max_x100 < high_x97) n.over_high = 1'b0;
      // low limit drops out at 103 percent
      if (imax < s.lim_low) n.under_low = 1'b1;
      else if (max_x100 > low_x103) n.under_low = 1'b0;
      if (dsel < s.isum) n.diff_low = 1'b1;
      else if (diff_x100 > isum_x103) n.diff_low = 1'b0;
    end
    pickup = ~n.over_high && ~n.under_low && ratio_ok && unbal_ok
             && ((s.ctrl.res_sel == cts_pkg::RES_NONE) || ~n.diff_low);
    if (tick_in) begin
      if (off_mode) begin
        n.start   = 1'b0;
        n.blocked = 1'b0;
        n.alarm   = 1'b0;
        n.timer   = 19'h00000;
      end else if (pickup && n.blk) begin
        n.blocked = 1'b1;
        n.start   = 1'b0;
        n.alarm   = 1'b0;
        n.timer   = 19'h00000;
      end else if (pickup) begin
        n.blocked = 1'b0;
        n.start   = 1'b1;
        if (s.timer >= s.delay) n.alarm = 1'b1;
        else n.timer = s.timer + 19'h00001;
      end else begin
        n.start   = 1'b0;
        n.blocked = 1'b0;
        n.alarm   = 1'b0;
        n.timer   = 19'h00000;
      end
    end
    ev_alarm_on = n.alarm && ~s.alarm;
    ev_block_on = n.blocked && ~s.blocked;
    n.events[cts_pkg::EV_ALARM_ON]  = ev_alarm_on && s.ctrl.ev_mask[cts_pkg::EV_ALARM_ON];
    n.events[cts_pkg::EV_ALARM_OFF] = ~n.alarm && s.alarm
                                      && s.ctrl.ev_mask[cts_pkg::EV_ALARM_OFF];
    n.events[cts_pkg::EV_BLOCK_ON]  = ev_block_on && s.ctrl.ev_mask[cts_pkg::EV_BLOCK_ON];
    n.events[cts_pkg::EV_BLOCK_OFF] = ~n.blocked && s.blocked
                                      && s.ctrl.ev_mask[cts_pkg::EV_BLOCK_OFF];
    // a clear in the same cycle applies first, then the count adds one
    if (ev_alarm_on || ev_block_on) n.count = n.count + 32'h00000001;
    if (ev_alarm_on || ev_block_on) begin
      n.recs[s.rec_wp].stamp    = time_in;
      n.recs[s.rec_wp].event_id = ev_alarm_on ? 2'(cts_pkg::EV_ALARM_ON)
                                              : 2'(cts_pkg::EV_BLOCK_ON);
      n.recs[s.rec_wp].fault    = fault;
      n.recs[s.rec_wp].group    = group_in;
      n.recs[s.rec_wp].remain   = remain;
      n.recs[s.rec_wp].cur      = meas_in.cur;
      n.rec_wp = (s.rec_wp == 4'(cts_pkg::REC_DEPTH - 1)) ? 4'h0 : s.rec_wp + 4'h1;
      if (s.rec_cnt != 4'(cts_pkg::REC_DEPTH)) n.rec_cnt = s.rec_cnt + 4'h1;
    end
  end

  // Selector 0 is the newest record
  always_comb begin
    rd_slot = 5'(s.rec_wp) + 5'(cts_pkg::REC_DEPTH) - 5'h01 - 5'(s.rec_sel);
    if (rd_slot >= 5'(cts_pkg::REC_DEPTH)) rd_slot = rd_slot - 5'(cts_pkg::REC_DEPTH);
    rd_rec = '0;
    if ((s.rec_sel < s.rec_cnt) && (rd_slot < 5'(cts_pkg::REC_DEPTH))) begin
      rd_rec = s.recs[rd_slot[3:0]];
    end
  end

  always_comb begin
    rdata_out = 32'h00000000;
    case (reg_ofs_in)
      cts_pkg::OFS_CTRL:   rdata_out = s.ctrl;
      cts_pkg::OFS_LIMITS: rdata_out = {s.lim_high, s.lim_low};
      cts_pkg::OFS_RATIOS: rdata_out = {2'h0, s.rat_unbal, 2'h0, s.rat_minmax};
      cts_pkg::OFS_ISUM:   rdata_out = {16'h0000, s.isum};
      cts_pkg::OFS_DELAY:  rdata_out = {13'h0000, s.delay};
      cts_pkg::OFS_STATUS: rdata_out = {21'h000000, fault, s.alarm, s.blocked, s.start, behav};
      cts_pkg::OFS_COUNT:  rdata_out = s.count;
      cts_pkg::OFS_RECSEL: rdata_out = {20'h00000, s.rec_cnt, 4'h0, s.rec_sel};
      cts_pkg::OFS_REC0:   rdata_out = rd_rec.stamp;
      cts_pkg::OFS_REC1:   rdata_out = {rd_rec.event_id, 1'b0, rd_rec.fault, 1'b0,
                                        rd_rec.group, 1'b0, rd_rec.remain};
      cts_pkg::OFS_REC2:   rdata_out = {rd_rec.cur.l1, rd_rec.cur.l2};
      cts_pkg::OFS_REC3:   rdata_out = {rd_rec.cur.l3, rd_rec.cur.res1};
      cts_pkg::OFS_REC4:   rdata_out = {rd_rec.cur.res2, rd_rec.cur.pos};
      cts_pkg::OFS_REC5:   rdata_out = {16'h0000, rd_rec.cur.neg};
      default:             rdata_out = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s            <= '0;
      s.ctrl       <= cts_pkg::CTRL_RST;
      s.lim_high   <= cts_pkg::HIGH_RST;
      s.lim_low    <= cts_pkg::LOW_RST;
      s.rat_minmax <= cts_pkg::MINMAX_RST;
      s.rat_unbal  <= cts_pkg::UNBAL_RST;
      s.isum       <= cts_pkg::ISUM_RST;
      s.delay      <= cts_pkg::DELAY_RST;
    end else begin
      s <= n;
    end
  end

  assign alarm_out   = s.alarm;
  assign start_out   = s.start;
  assign blocked_out = s.blocked;
  assign event_out   = s.events;
endmodule

module current_transformer_supervision #(
  parameter int unsigned CYCLE_CLKS = cts_pkg::CYCLE_CLKS  // Clocks per program cycle
) (
  input  wire logic           mclk_in,       // System clock, 25 MHz
  input  wire logic           rst_n_in,      // Synchronous reset, active low
  input  wire logic           hsel_in,       // AHB slave select
  input  wire logic [31:0]    haddr_in,      // AHB address
  input  wire logic [1:0]     htrans_in,     // AHB transfer type
  input  wire logic           hwrite_in,     // AHB write
  input  wire logic [2:0]     hsize_in,      // AHB size, word only
  input  wire logic [31:0]    hwdata_in,     // AHB write data
  input  wire logic           hready_in,     // AHB bus ready
  output logic                hreadyout_out, // AHB slave ready
  output logic [31:0]         hrdata_out,    // AHB read data
  output logic                hresp_out,     // AHB response, always OKAY
  input  cts_pkg::meas_t      meas_in,       // Measured magnitudes
  input  cts_pkg::info_t      info_in,       // Unbalance and difference values
  input  wire logic [31:0]    time_in,       // Millisecond time stamp
  input  wire logic [2:0]     group_in,      // Active setting group
  input  wire logic [1:0]     block_in,      // Blocking, one per stage
  output logic [1:0]          alarm_out,     // Alarm per stage
  output logic [1:0]          start_out,     // Start per stage
  output logic [1:0]          blocked_out,   // Blocked per stage
  output logic [7:0]          event_out      // Event pulses, four per stage
);
  cts_pkg::top_t s;
  cts_pkg::top_t n;
  logic [31:0] stage_rd [cts_pkg::STAGES];
  logic [31:0] rd_mux;
  logic        unused_size;

  // Word transfers only, size is not decoded
  assign unused_size = ^hsize_in;

  always_comb begin
    rd_mux = 32'h00000000;
    if (!s.ofs[7]) begin
      rd_mux = stage_rd[s.ofs[6]];
    end else begin
      case (s.ofs)
        cts_pkg::OFS_UNBAL_ANG: rd_mux = {16'h0000, info_in.unbal_ang};
        cts_pkg::OFS_DIFF_MAG:  rd_mux = {16'h0000, info_in.diff_mag};
        cts_pkg::OFS_DIFF_ANG:  rd_mux = {16'h0000, info_in.diff_ang};
        default:                rd_mux = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    n = s;
    n.tick = 1'b0;
    // Program cycle divider
    if (32'(s.tick_cnt) == CYCLE_CLKS - 1) begin
      n.tick_cnt = '0;
      n.tick     = 1'b1;
    end else begin
      n.tick_cnt = s.tick_cnt + 1'b1;
    end
    n.wr_pend = 1'b0;
    n.rd_pend = 1'b0;
    n.hready  = 1'b1;
    n.hresp   = 1'b0;
    // Reads take one wait state so read data comes from a flop
    if (s.rd_pend) n.hrdata = rd_mux;
    if (hsel_in && htrans_in[1] && hready_in) begin
      n.ofs     = haddr_in[7:0];
      n.wr_pend = hwrite_in;
      n.rd_pend = ~hwrite_in;
      n.hready  = hwrite_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s        <= '0;
      s.hready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  for (genvar j = 0; j < cts_pkg::STAGES; j++) begin : g_stage
    cts_stage u_stage (
      .mclk_in     (mclk_in),
      .rst_n_in    (rst_n_in),
      .tick_in     (s.tick),
      .block_in    (block_in[j]),
      .time_in     (time_in),
      .group_in    (group_in),
      .meas_in     (meas_in),
      .reg_wr_in   (s.wr_pend && !s.ofs[7] && (s.ofs[6] == 1'(j))),
      .reg_ofs_in  (s.ofs[5:0]),
      .wdata_in    (hwdata_in),
      .rdata_out   (stage_rd[j]),
      .alarm_out   (alarm_out[j]),
      .start_out   (start_out[j]),
      .blocked_out (blocked_out[j]),
      .event_out   (event_out[4*j +: 4])
    );
  end

  assign hreadyout_out = s.hready;
  assign hrdata_out    = s.hrdata;
  assign hresp_out     = s.hresp;
endmodule

// ===== bench/cts_front_model.sv
// Measurement front end and blocking source in front of the supervision block
module cts_front_model (
  input  wire logic [2:0] pat_in,     // Current pattern select
  input  wire logic [1:0] blk_req_in, // Blocking request per stage
  output cts_pkg::meas_t  meas_out,   // Magnitudes in 0.01 x In
  output logic [1:0]      block_out   // Blocking lines
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    meas_out = '0;
    // Default set: phase one lost, sequence ratio just above 49 percent
    meas_out.cur.l2 = 16'h0064;
    meas_out.cur.l3 = 16'h0064;
    meas_out.cur.pos = 16'h0043;
    meas_out.cur.neg = 16'h0021;
    meas_out.diff1 = 16'h0032;
    case (pat_in)
      3'h0: begin
        meas_out.cur.l1 = 16'h0064;
        meas_out.cur.pos = 16'h0064;
        meas_out.cur.neg = 16'h0000;
      end
      3'h2: meas_out.cur.l3 = 16'h00C8;
      3'h3: begin
        meas_out.cur.l2 = 16'h0005;
        meas_out.cur.l3 = 16'h0005;
        meas_out.cur.pos = 16'h0003;
        meas_out.cur.neg = 16'h0002;
      end
      3'h4: meas_out.cur.l1 = 16'h0014;
      3'h5: meas_out.diff1 = 16'h0002;
      default: ;
    endcase
  end
  assign block_out = blk_req_in;
endmodule

// ===== bench/cts_monitor.sv
// Port-level assertions for the supervision block
module cts_monitor #(
  parameter int unsigned CYCLE_CLKS = 20  // Clocks per program cycle
) (
  input wire logic       mclk_in,       // System clock
  input wire logic       rst_n_in,      // Synchronous reset, active low
  input wire logic       hsel_in,       // AHB select
  input wire logic [1:0] htrans_in,     // AHB transfer type
  input wire logic       hwrite_in,     // AHB write
  input wire logic       hready_in,     // AHB bus ready
  input wire logic       hreadyout_out, // Slave ready
  input wire logic       hresp_out,     // Slave response
  input cts_pkg::meas_t  meas_in,       // Measured magnitudes
  input wire logic [1:0] alarm_out,     // Alarm per stage
  input wire logic [1:0] start_out,     // Start per stage
  input wire logic [1:0] blocked_out,   // Blocked per stage
  input wire logic [7:0] event_out      // Event pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mx_a;
  logic [15:0] mx;
  // Largest phase; limits hold at their reset values in the bench
  assign mx_a = (meas_in.cur.l1 > meas_in.cur.l2) ? meas_in.cur.l1 : meas_in.cur.l2;
  assign mx   = (mx_a > meas_in.cur.l3) ? mx_a : meas_in.cur.l3;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rd; hsel_in && htrans_in[1] && !hwrite_in && hready_in; endsequence
  sequence s_wait; !hreadyout_out ##1 hreadyout_out; endsequence
  property p_rd_wait; s_rd |=> s_wait; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("Read wait state wrong");
  property p_okay; hresp_out == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("Response not OKAY");
  property p_blk; blocked_out[0] |-> !start_out[0] && !alarm_out[0]; endproperty
  a_blk: assert property (p_blk) else $error("Blocked stage still running");
  // Start of stage one holds for eight clocks after each change
  property p_hold; $changed(start_out[0]) |=> $stable(start_out[0]) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("Start moved between ticks");
  property p_over; $rose(start_out[0]) |-> $past(mx) <= cts_pkg::HIGH_RST; endproperty
  a_over: assert property (p_over) else $error("Start above high limit");
  property p_low; $rose(start_out[0]) |-> $past(mx) >= cts_pkg::LOW_RST; endproperty
  a_low: assert property (p_low) else $error("Start below low limit");
  property p_aon; $rose(alarm_out[0]) |-> event_out[0]; endproperty
  a_aon: assert property (p_aon) else $error("Alarm on event missing");
  property p_aoff; $fell(alarm_out[0]) |-> event_out[1]; endproperty
  a_aoff: assert property (p_aoff) else $error("Alarm off event missing");
  property p_bon; $rose(blocked_out[0]) |-> event_out[2]; endproperty
  a_bon: assert property (p_bon) else $error("Block on event missing");
  property p_alarm; $rose(alarm_out[0]) |-> $past(start_out[0]); endproperty
  a_alarm: assert property (p_alarm) else $error("Alarm without start");
endmodule

bind current_transformer_supervision cts_monitor #(.CYCLE_CLKS(CYCLE_CLKS)) cts_monitor_inst (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .meas_in(meas_in), .alarm_out(alarm_out), .start_out(start_out),
  .blocked_out(blocked_out), .event_out(event_out));

// ===== bench/current_transformer_supervision_test.sv
// Self-checking bench for the current transformer supervision block
module current_transformer_supervision_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC = 20;
  typedef struct packed {
    logic [11:0] ctrl;
    logic [2:0]  pat;
    logic [1:0]  blk;
    logic [2:0]  exp;
  } row_t;
  logic           mclk_in   = 1'b0;
  logic           rst_n_in  = 1'b0;
  logic           hsel_in   = 1'b0;
  logic [31:0]    haddr_in  = '0;
  logic [1:0]     htrans_in = '0;
  logic           hwrite_in = 1'b0;
  logic [31:0]    hwdata_in = '0;
  logic           hreadyout_out;
  logic           hresp_out;
  logic [31:0]    hrdata_out;
  cts_pkg::meas_t meas;
  cts_pkg::info_t info = '{16'h0123, 16'h0045, 16'h0067};
  logic [2:0]     pat = '0;
  logic [1:0]     blk = '0;
  logic [1:0]     block, alarm, start, blocked;
  logic [7:0]     events, ev_acc;
  logic           ev_clr = 1'b1;
  logic [2:0]     outs, outs2;
  logic [31:0]    rd;
  int             errors = 0;
  int             n_compared = 0;
  int             k;
  row_t rows [15] = '{
    '{12'h1E0, 3'h0, 2'h0, 3'h0},
    '{12'h1E0, 3'h1, 2'h0, 3'h5},
    '{12'h1E0, 3'h2, 2'h0, 3'h0},
    '{12'h1E0, 3'h3, 2'h0, 3'h0},
    '{12'h1E0, 3'h4, 2'h0, 3'h0},
    '{12'h1E0, 3'h1, 2'h3, 3'h2},
    '{12'h1E0, 3'h0, 2'h0, 3'h0},
    '{12'h1E8, 3'h5, 2'h0, 3'h0},
    '{12'h1E8, 3'h1, 2'h0, 3'h5},
    '{12'h1E0, 3'h0, 2'h0, 3'h0},
    '{12'h1E1, 3'h1, 2'h0, 3'h2},
    '{12'h1E2, 3'h1, 2'h0, 3'h5},
    '{12'h1E0, 3'h0, 2'h0, 3'h0},
    '{12'h1E4, 3'h1, 2'h0, 3'h0},
    '{12'h1E0, 3'h0, 2'h0, 3'h0}};

  current_transformer_supervision #(.CYCLE_CLKS(CYC)) current_transformer_supervision_inst (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out),
    .hresp_out(hresp_out), .meas_in(meas), .info_in(info), .time_in(32'h00001234),
    .group_in(3'h5), .block_in(block), .alarm_out(alarm), .start_out(start),
    .blocked_out(blocked), .event_out(events));
  cts_front_model cts_front_model_inst (.pat_in(pat), .blk_req_in(blk), .meas_out(meas),
    .block_out(block));

  always #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in) ev_acc <= ev_clr ? 8'h00 : (ev_acc | events);
  // Snapshot at the falling edge so reads never race the design's updates
  always @(negedge mclk_in) outs <= {start[0], blocked[0], alarm[0]};
  always @(negedge mclk_in) outs2 <= {start[1], blocked[1], alarm[1]};

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic rdy_edge;
    @(negedge mclk_in);
    while (hreadyout_out !== 1'b1) @(negedge mclk_in);
    rd = hrdata_out;
    @(posedge mclk_in);
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    haddr_in <= {24'h0, a};
    rdy_edge;
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    rdy_edge;
  endtask
  task automatic wait_start;
    k = 0;
    while (outs[2] !== 1'b1 && k < 200) begin
      @(posedge mclk_in);
      k++;
    end
    if (k >= 200) begin
      errors++;
      $display("Error start expected 1 seen %b", outs[2]);
    end
  endtask
  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    cyc(6);
    rst_n_in <= 1'b1;
    cyc(1);
    bus(1'b1, 8'h10, 32'h3);
    bus(1'b1, 8'h40, 32'h40);
    ev_clr <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b1, 8'h00, {20'h0, rows[i].ctrl});
      pat <= rows[i].pat;
      blk <= rows[i].blk;
      cyc(5 * CYC);
      chk("stage outputs", {29'h0, rows[i].exp}, {29'h0, outs});
    end
    // Stage two keeps only alarm off, and never alarms here
    chk("event summary", 32'h0F, {24'h0, ev_acc});
    $display("Row table done");
    for (int m = 0; m < 5; m++) begin
      bus(1'b1, 8'h00, 32'h1E0 | m);
      bus(1'b0, 8'h14, 32'h0);
      chk("behaviour", m, {29'h0, rd[2:0]});
    end
    bus(1'b1, 8'h00, 32'h1E0);
    bus(1'b0, 8'h80, 32'h0);
    chk("unbalance angle", 32'h0123, {16'h0, rd[15:0]});
    bus(1'b0, 8'hF0, 32'h0);
    chk("unmapped read", 32'h0, rd);
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b0, 8'h18, 32'h0);
    chk("count cleared", 32'h0, rd);
    $display("Register tests done");
    pat <= 3'h1;
    wait_start;
    k = 0;
    while (outs[0] !== 1'b1 && k < 200) begin
      @(posedge mclk_in);
      k++;
    end
    chk("alarm delay", 3 * CYC, k);
    chk("stage two running", 32'h4, {29'h0, outs2});
    bus(1'b0, 8'h20, 32'h0);
    chk("record stamp", 32'h00001234, rd);
    bus(1'b0, 8'h24, 32'h0);
    chk("record info", 32'h00500000, rd & 32'hC077FFFF);
    bus(1'b0, 8'h30, 32'h0);
    chk("record currents", 32'h00000043, rd);
    bus(1'b0, 8'h18, 32'h0);
    chk("count alarm", 32'h1, rd);
    blk <= 2'h3;
    cyc(2 * CYC);
    chk("block over start", 32'h2, {29'h0, outs});
    chk("stage two blocked", 32'h2, {29'h0, outs2});
    bus(1'b0, 8'h18, 32'h0);
    chk("count block", 32'h2, rd);
    blk <= 2'h0;
    pat <= 3'h0;
    cyc(2 * CYC);
    bus(1'b1, 8'h18, 32'h0);
    pat <= 3'h1;
    wait_start;
    // Drop the fault long before the three-cycle delay runs out
    pat <= 3'h0;
    cyc(5 * CYC);
    bus(1'b0, 8'h18, 32'h0);
    chk("count after early loss", 32'h0, rd);
    $display("Timing tests done");
    pat <= 3'h1;
    repeat (13) begin
      blk <= 2'h3;
      cyc(CYC + 5);
      blk <= 2'h0;
      cyc(CYC + 5);
    end
    pat <= 3'h0;
    bus(1'b0, 8'h1C, 32'h0);
    chk("records held", 32'hC, {28'h0, rd[11:8]});
    bus(1'b0, 8'h24, 32'h0);
    chk("newest event", 32'h2, {30'h0, rd[31:30]});
    $display("Record tests done");
    // Mid-run reset while both stages run
    pat <= 3'h1;
    wait_start;
    rst_n_in <= 1'b0;
    cyc(2);
    chk("outputs in reset", 32'h0, {26'h0, outs2, outs});
    rst_n_in <= 1'b1;
    cyc(1);
    bus(1'b0, 8'h10, 32'h0);
    chk("delay after reset", 32'h64, rd);
    $display("Reset tests done");
    summarize;
  end

  initial begin
    #800us;
    errors++;
    $display("Watchdog expired");
    summarize;
  end
endmodule
